// >>> rtl/cpu_flag_alu.sv
// Combinational ALU producing result and carry, auxiliary carry and overflow
`timescale 1ns/1ps
module cpu_flag_alu (
    input  wire cpu_regs_pkg::alu_op_t  op_i,       // Operation
    input  wire logic                   byte_i,     // Byte width
    input  wire logic [15:0]            a_i,        // Left operand
    input  wire logic [15:0]            b_i,        // Right operand
    input  wire logic                   carry_in_i, // Carry for adc and sbb
    output cpu_regs_pkg::alu_res_t      res_o       // Result and arithmetic flags
);
    logic [16:0] wide;
    logic [4:0]  nib;
    logic        cin;
    logic        sub;
    logic        arith;
    logic        top_a;
    logic        top_b;
    logic        top_r;

    always_comb begin
        sub   = (op_i == cpu_regs_pkg::OP_SUB) || (op_i == cpu_regs_pkg::OP_SBB);
        arith = sub || (op_i == cpu_regs_pkg::OP_ADD) || (op_i == cpu_regs_pkg::OP_ADC);
        cin   = ((op_i == cpu_regs_pkg::OP_ADC) || (op_i == cpu_regs_pkg::OP_SBB))
                && carry_in_i;
        wide  = 17'h00000;
        nib   = 5'h00;
        res_o = '0;
        unique case (op_i)
            cpu_regs_pkg::OP_AND:  wide = {1'b0, a_i & b_i};
            cpu_regs_pkg::OP_OR:   wide = {1'b0, a_i | b_i};
            cpu_regs_pkg::OP_XOR:  wide = {1'b0, a_i ^ b_i};
            cpu_regs_pkg::OP_PASS: wide = {1'b0, b_i};
            default: begin
                if (sub) begin
                    wide = {1'b0, a_i} - {1'b0, b_i} - {16'h0000, cin};
                    nib  = {1'b0, a_i[3:0]} - {1'b0, b_i[3:0]} - {4'h0, cin};
                end else begin
                    wide = {1'b0, a_i} + {1'b0, b_i} + {16'h0000, cin};
                    nib  = {1'b0, a_i[3:0]} + {1'b0, b_i[3:0]} + {4'h0, cin};
                end
            end
        endcase
        // Byte carry comes from bit 8 of the 9-bit sum of zero-extended bytes
        top_a = byte_i ? a_i[7] : a_i[15];
        top_b = (byte_i ? b_i[7] : b_i[15]) ^ sub;
        top_r = byte_i ? wide[7] : wide[15];
        res_o.result = byte_i ? {8'h00, wide[7:0]} : wide[15:0];
        if (arith) begin
            if (byte_i) begin
                res_o.carry = ({1'b0, a_i[7:0]} + (sub ? -{1'b0, b_i[7:0]} - {8'h00, cin}
                              : {1'b0, b_i[7:0]} + {8'h00, cin})) >> 8 != 9'h000;
            end else begin
                res_o.carry = wide[16];
            end
            res_o.aux = nib[4];
            res_o.ovf = (top_a == top_b) && (top_r != top_a);
        end
    end
endmodule // cpu_flag_alu

// >>> rtl/cpu_gpr_file.sv
// Eight 16-bit general registers with byte-half writes and registered read
`timescale 1ns/1ps
module cpu_gpr_file (
    input  wire logic        clk_i,     // Processor clock
    input  wire logic        we_lo_i,   // Write low byte
    input  wire logic        we_hi_i,   // Write high byte
    input  wire logic [2:0]  waddr_i,   // Write register
    input  wire logic [15:0] wdata_i,   // Write data
    input  wire logic [2:0]  raddr_i,   // Read register
    output logic      [15:0] rdata_o    // Registered read data
);
    // No reset: the general registers keep their contents across reset
    logic [15:0] mem [cpu_regs_pkg::NUM_GPR];

    always_ff @(posedge clk_i) begin
        if (we_lo_i) begin
            mem[waddr_i][7:0] <= wdata_i[7:0];
        end
        if (we_hi_i) begin
            mem[waddr_i][15:8] <= wdata_i[15:8];
        end
        rdata_o <= mem[raddr_i];
    end
endmodule // cpu_gpr_file

// >>> rtl/cpu_regs_pkg.sv
// Package of constants and carrier types for the processor register and flag datapath
package cpu_regs_pkg;

    // ------------------------------------------------------------
    // Register map (byte offsets on the bus)
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_GPR0       = 8'h00;  // 0x00..0x1c: eight general words
    localparam logic [7:0] OFS_STATUS     = 8'h20;
    localparam logic [7:0] OFS_CODE_SEG   = 8'h24;
    localparam logic [7:0] OFS_DATA_SEG   = 8'h28;
    localparam logic [7:0] OFS_EXTRA_SEG  = 8'h2c;
    localparam logic [7:0] OFS_STACK_SEG  = 8'h30;
    localparam logic [7:0] OFS_INSTR_PTR  = 8'h34;
    localparam logic [7:0] OFS_PINS       = 8'h38;  // Read-only synchronised input lines
    localparam logic [7:0] OFS_FETCH_ADDR = 8'h3c;  // Read-only fetch address
    localparam logic [7:0] OFS_INDEX      = 8'h44;  // Read-only index copies

    // ------------------------------------------------------------
    // Status word layout
    // ------------------------------------------------------------
    localparam int BIT_CARRY  = 0;
    localparam int BIT_PARITY = 2;
    localparam int BIT_AUX    = 4;
    localparam int BIT_ZERO   = 6;
    localparam int BIT_SIGN   = 7;
    localparam int BIT_TRAP   = 8;
    localparam int BIT_IE     = 9;
    localparam int BIT_DIR    = 10;
    localparam int BIT_OVF    = 11;
    localparam logic [15:0] STATUS_MASK  = 16'h0fd5;
    localparam logic [15:0] STATUS_FIXED = 16'h0000;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [15:0] RST_CODE_SEG = 16'hffff;
    localparam logic [15:0] RST_ZERO     = 16'h0000;

    // ------------------------------------------------------------
    // Operations and types
    // ------------------------------------------------------------
    localparam int NUM_GPR = 8;
    localparam logic [7:0] TRAP_VECTOR = 8'h01;
    localparam logic [7:0] NMI_VECTOR  = 8'h02;

    typedef enum logic [2:0] {
        OP_ADD = 3'h0,
        OP_SUB = 3'h1,
        OP_AND = 3'h2,
        OP_OR  = 3'h3,
        OP_XOR = 3'h4,
        OP_ADC = 3'h5,
        OP_SBB = 3'h6,
        OP_PASS= 3'h7
    } alu_op_t;

    typedef struct packed {
        logic        valid;     // Execute one instruction's ALU step
        alu_op_t     op;
        logic        byte_op;   // Operate on the low 8 bits
        logic [2:0]  dst;       // Destination general register
        logic        dst_high;  // Byte op writes the high half (regs 0..3)
        logic [15:0] a;
        logic [15:0] b;
        logic        string_step; // Step the selected index register
        logic [2:0]  index_sel;
        logic [15:0] next_ip;   // Instruction pointer after this instruction
    } exec_req_t;

    typedef struct packed {
        logic [15:0] result;
        logic        carry;
        logic        aux;
        logic        ovf;
    } alu_res_t;

    typedef struct packed {
        logic [1:0]  seg_sel;   // 0 extra, 1 code, 2 stack, 3 data
        logic [15:0] offset;
    } addr_req_t;

    typedef enum logic [1:0] {
        SEG_EXTRA = 2'h0,
        SEG_CODE  = 2'h1,
        SEG_STACK = 2'h2,
        SEG_DATA  = 2'h3
    } seg_t;

endpackage

// >>> rtl/cpu_status_regs.sv
// Top of the processor status flag and segment register datapath with AHB-Lite access
`timescale 1ns/1ps
module cpu_status_regs (
    input  wire logic                    clk_i,        // Processor clock, 50 MHz
    input  wire logic                    reset_i,      // Asynchronous reset, active high
    // AHB-Lite slave
    input  wire logic                    hsel_i,       // Slave select
    input  wire logic [31:0]             haddr_i,      // Address
    input  wire logic [1:0]              htrans_i,     // Transfer type
    input  wire logic                    hwrite_i,     // Write
    input  wire logic [2:0]              hsize_i,      // Size
    input  wire logic [31:0]             hwdata_i,     // Write data
    input  wire logic                    hready_i,     // Bus ready
    output logic      [31:0]             hrdata_o,     // Read data
    output logic                         hreadyout_o,  // Slave ready
    output logic                         hresp_o,      // Response, always OKAY
    // Execution unit
    input  wire cpu_regs_pkg::exec_req_t exec_i,       // Instruction step
    input  wire cpu_regs_pkg::addr_req_t addr_i,       // Operand address request
    input  wire logic                    irq_ack_i,    // Maskable request taken
    // Pins
    input  wire logic                    maskable_irq_input_i, // Maskable request pin
    input  wire logic                    nmi_input_i,  // Non-maskable request pin
    input  wire logic                    test_input_i, // Wait-instruction test pin
    // Results
    output logic      [19:0]             fetch_addr_o, // Physical code fetch address
    output logic      [19:0]             phys_addr_o,  // Physical operand address
    output logic      [15:0]             status_o,     // Processor status word
    output logic                         irq_take_o,   // Maskable request accepted
    output logic                         trap_take_o,  // Single-step trap due
    output logic      [7:0]              vector_o,     // Vector of taken trap or nmi
    output logic                         test_o        // Synchronised test line
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic [15:0] status;
        logic [15:0] code_seg;
        logic [15:0] data_seg;
        logic [15:0] extra_seg;
        logic [15:0] stack_seg;
        logic [15:0] ip;
        logic [1:0][15:0] index_ptr;  // Source and destination index copies
        logic [1:0]  irq_sync;
        logic [1:0]  nmi_sync;
        logic [1:0]  test_sync;
        logic        nmi_prev;
        logic        aphase;
        logic        awrite;
        logic [7:0]  aaddr;
        logic        rd_gpr;
        logic [31:0] hrdata;
        logic [19:0] fetch_addr;
        logic [19:0] phys_addr;
        logic        irq_take;
        logic        trap_take;
        logic [7:0]  vector;
    } state_t;

    state_t st_r;
    state_t st_nxt;

    cpu_regs_pkg::alu_res_t alu_res;
    logic [15:0]            gpr_rdata;
    logic                   gpr_we_lo;
    logic                   gpr_we_hi;
    logic [2:0]             gpr_waddr;
    logic [15:0]            gpr_wdata;
    logic [2:0]             gpr_raddr;

    function automatic logic [19:0] phys(input logic [15:0] seg, input logic [15:0] ofs);
        phys = {seg, 4'h0} + {4'h0, ofs};   // Wraps at 1 MByte
    endfunction

    function automatic logic [15:0] clean_status(input logic [15:0] v);
        clean_status = (v & cpu_regs_pkg::STATUS_MASK) |
                       cpu_regs_pkg::STATUS_FIXED;
    endfunction

    function automatic logic [15:0] seg_of(input state_t s, input logic [1:0] sel);
        unique case (sel)
            cpu_regs_pkg::SEG_EXTRA: seg_of = s.extra_seg;
            cpu_regs_pkg::SEG_CODE:  seg_of = s.code_seg;
            cpu_regs_pkg::SEG_STACK: seg_of = s.stack_seg;
            default:                 seg_of = s.data_seg;
        endcase
    endfunction

    cpu_flag_alu u_alu (
        .op_i       (exec_i.op),
        .byte_i     (exec_i.byte_op),
        .a_i        (exec_i.a),
        .b_i        (exec_i.b),
        .carry_in_i (st_r.status[cpu_regs_pkg::BIT_CARRY]),
        .res_o      (alu_res)
    );

    cpu_gpr_file u_gpr (
        .clk_i   (clk_i),
        .we_lo_i (gpr_we_lo),
        .we_hi_i (gpr_we_hi),
        .waddr_i (gpr_waddr),
        .wdata_i (gpr_wdata),
        .raddr_i (gpr_raddr),
        .rdata_o (gpr_rdata)
    );

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    logic        bus_wr;
    logic [15:0] wd;
    logic [15:0] r8;
    logic        nmi_edge;
    logic        is_zero;

    always_comb begin
        st_nxt    = st_r;
        gpr_we_lo = 1'b0;
        gpr_we_hi = 1'b0;
        gpr_waddr = exec_i.dst;
        gpr_wdata = alu_res.result;
        gpr_raddr = haddr_i[4:2];
        wd        = hwdata_i[15:0];
        r8        = 16'h0000;
        is_zero   = 1'b0;

        // Pins pass two flops; stage one feeds only stage two
        st_nxt.irq_sync  = {st_r.irq_sync[0], maskable_irq_input_i};
        st_nxt.nmi_sync  = {st_r.nmi_sync[0], nmi_input_i};
        st_nxt.test_sync = {st_r.test_sync[0], test_input_i};
        st_nxt.nmi_prev  = st_r.nmi_sync[1];
        nmi_edge = st_r.nmi_sync[1] && !st_r.nmi_prev;

        // Bus address phase; this slave is always ready
        st_nxt.rd_gpr = 1'b0;
        if (hready_i) begin
            st_nxt.aphase = hsel_i && htrans_i[1];
            st_nxt.awrite = hwrite_i;
            st_nxt.aaddr  = haddr_i[7:0];
            if (hsel_i && htrans_i[1] && !hwrite_i && haddr_i[7:0] < cpu_regs_pkg::OFS_STATUS)
                st_nxt.rd_gpr = 1'b1;
        end
        bus_wr = st_r.aphase && st_r.awrite;

        // Instruction step: flags from the result
        st_nxt.irq_take  = 1'b0;
        st_nxt.trap_take = 1'b0;
        if (exec_i.valid) begin
            if (exec_i.op != cpu_regs_pkg::OP_PASS) begin
                r8      = alu_res.result;
                is_zero = exec_i.byte_op ? (r8[7:0] == 8'h00) : (r8 == 16'h0000);
                st_nxt.status[cpu_regs_pkg::BIT_CARRY]  = alu_res.carry;
                st_nxt.status[cpu_regs_pkg::BIT_PARITY] = ~^r8[7:0];
                st_nxt.status[cpu_regs_pkg::BIT_AUX]    = alu_res.aux;
                st_nxt.status[cpu_regs_pkg::BIT_ZERO]   = is_zero;
                st_nxt.status[cpu_regs_pkg::BIT_SIGN]   =
                    exec_i.byte_op ? r8[7] : r8[15];
                st_nxt.status[cpu_regs_pkg::BIT_OVF]    = alu_res.ovf;
            end
            gpr_we_lo = !(exec_i.byte_op && exec_i.dst_high);
            gpr_we_hi = !exec_i.byte_op || exec_i.dst_high;
            if (exec_i.byte_op && exec_i.dst_high)
                gpr_wdata = {alu_res.result[7:0], 8'h00};
            st_nxt.ip = exec_i.next_ip;
            // String step: decrement when direction set, else increment
            if (exec_i.string_step) begin
                st_nxt.index_ptr[exec_i.index_sel[0]] =
                    st_r.status[cpu_regs_pkg::BIT_DIR] ?
                    st_r.index_ptr[exec_i.index_sel[0]] - 16'h0001 :
                    st_r.index_ptr[exec_i.index_sel[0]] + 16'h0001;
            end
            // Trap fires after the instruction that began with the flag set
            if (st_r.status[cpu_regs_pkg::BIT_TRAP]) begin
                st_nxt.trap_take = 1'b1;
                st_nxt.vector    = cpu_regs_pkg::TRAP_VECTOR;
                st_nxt.status[cpu_regs_pkg::BIT_TRAP] = 1'b0;
                st_nxt.status[cpu_regs_pkg::BIT_IE]   = 1'b0;
            end
        end

        // Maskable request is accepted only with interrupts enabled
        if (st_r.irq_sync[1] && st_r.status[cpu_regs_pkg::BIT_IE] && !st_nxt.trap_take
            && !irq_ack_i)
            st_nxt.irq_take = 1'b1;
        if (irq_ack_i && st_r.irq_take)
            st_nxt.status[cpu_regs_pkg::BIT_IE] = 1'b0;
        if (nmi_edge && !st_nxt.trap_take)
            st_nxt.vector = cpu_regs_pkg::NMI_VECTOR;

        // Bus writes; pins are not writable, so the pin word ignores writes
        if (bus_wr) begin
            if (st_r.aaddr < cpu_regs_pkg::OFS_STATUS) begin
                gpr_we_lo = 1'b1;
                gpr_we_hi = 1'b1;
                gpr_waddr = st_r.aaddr[4:2];
                gpr_wdata = wd;
            end
            unique case (st_r.aaddr)
                cpu_regs_pkg::OFS_STATUS:    st_nxt.status    = wd;
                cpu_regs_pkg::OFS_CODE_SEG:  st_nxt.code_seg  = wd;
                cpu_regs_pkg::OFS_DATA_SEG:  st_nxt.data_seg  = wd;
                cpu_regs_pkg::OFS_EXTRA_SEG: st_nxt.extra_seg = wd;
                cpu_regs_pkg::OFS_STACK_SEG: st_nxt.stack_seg = wd;
                cpu_regs_pkg::OFS_INSTR_PTR: st_nxt.ip        = wd;
                default: ;
            endcase
        end
        st_nxt.status = clean_status(st_nxt.status);

        // Addresses
        st_nxt.fetch_addr = phys(st_nxt.code_seg, st_nxt.ip);
        st_nxt.phys_addr  = phys(seg_of(st_r, addr_i.seg_sel), addr_i.offset);

        // Read data
        st_nxt.hrdata = 32'h00000000;
        if (hready_i && hsel_i && htrans_i[1] && !hwrite_i) begin
            unique case (haddr_i[7:0])
                cpu_regs_pkg::OFS_STATUS:     st_nxt.hrdata = {16'h0000, st_r.status};
                cpu_regs_pkg::OFS_CODE_SEG:   st_nxt.hrdata = {16'h0000, st_r.code_seg};
                cpu_regs_pkg::OFS_DATA_SEG:   st_nxt.hrdata = {16'h0000, st_r.data_seg};
                cpu_regs_pkg::OFS_EXTRA_SEG:  st_nxt.hrdata = {16'h0000, st_r.extra_seg};
                cpu_regs_pkg::OFS_STACK_SEG:  st_nxt.hrdata = {16'h0000, st_r.stack_seg};
                cpu_regs_pkg::OFS_INSTR_PTR:  st_nxt.hrdata = {16'h0000, st_r.ip};
                cpu_regs_pkg::OFS_PINS:       st_nxt.hrdata = {29'h00000000,
                    st_r.test_sync[1], st_r.nmi_sync[1], st_r.irq_sync[1]};
                cpu_regs_pkg::OFS_FETCH_ADDR: st_nxt.hrdata = {12'h000, st_r.fetch_addr};
                cpu_regs_pkg::OFS_INDEX:      st_nxt.hrdata = st_r.index_ptr;
                default: ;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            st_r           <= '0;
            st_r.code_seg  <= cpu_regs_pkg::RST_CODE_SEG;
            st_r.status    <= cpu_regs_pkg::RST_ZERO;
            st_r.fetch_addr <= {cpu_regs_pkg::RST_CODE_SEG, 4'h0};
        end else begin
            st_r <= st_nxt;
        end
    end

    // General-register reads come from the file's own output register
    assign hrdata_o     = st_r.rd_gpr ? {16'h0000, gpr_rdata} : st_r.hrdata;
    assign hreadyout_o  = 1'b1;
    assign hresp_o      = 1'b0;
    assign fetch_addr_o = st_r.fetch_addr;
    assign phys_addr_o  = st_r.phys_addr;
    assign status_o     = st_r.status;
    assign irq_take_o   = st_r.irq_take;
    assign trap_take_o  = st_r.trap_take;
    assign vector_o     = st_r.vector;
    assign test_o       = st_r.test_sync[1];

endmodule // cpu_status_regs

// >>> sim/cpu_status_regs_chk.sv
// Checker of flag, reset and interrupt behaviour at the datapath top ports
`timescale 1ns/1ps
module cpu_status_regs_chk (
    input wire logic                    clk_i,        // Processor clock
    input wire logic                    reset_i,      // Asynchronous reset
    input wire cpu_regs_pkg::exec_req_t exec_i,       // Instruction step
    input wire logic                    irq_ack_i,    // Request taken
    input wire logic [19:0]             fetch_addr_o, // Fetch address
    input wire logic [15:0]             status_o,     // Status word
    input wire logic                    irq_take_o,   // Request accepted
    input wire logic                    trap_take_o,  // Trap due
    input wire logic [7:0]              vector_o      // Taken vector
);
    logic [16:0] sum;
    logic        add_w, aux, ovf, par;
    assign sum   = {1'b0, exec_i.a} + {1'b0, exec_i.b};
    assign add_w = exec_i.valid && exec_i.op == cpu_regs_pkg::OP_ADD && !exec_i.byte_op;
    assign aux   = sum[4] ^ exec_i.a[4] ^ exec_i.b[4];
    assign ovf   = (exec_i.a[15] == exec_i.b[15]) && (sum[15] != exec_i.a[15]);
    assign par   = ~^sum[7:0];
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (reset_i);
    sequence trap_armed_s; status_o[8] && exec_i.valid; endsequence
    sequence trap_fired_s;
        ##[0:2] trap_take_o ##0 vector_o == cpu_regs_pkg::TRAP_VECTOR;
    endsequence
    rst_vals_a: assert property ($fell(reset_i) |-> status_o == 16'h0000
        && fetch_addr_o == 20'hffff0) else $error("reset values wrong");
    unused_bits_a: assert property ((status_o & ~cpu_regs_pkg::STATUS_MASK) == '0)
        else $error("unused status bit set");
    add_carry_a: assert property (add_w |=> status_o[0] == $past(sum[16]))
        else $error("carry flag wrong");
    add_parity_a: assert property (add_w |=> status_o[2] == $past(par))
        else $error("parity flag wrong");
    add_aux_a: assert property (add_w |=> status_o[4] == $past(aux))
        else $error("aux carry flag wrong");
    add_zero_a: assert property (add_w |=> status_o[6] == ($past(sum[15:0]) == '0))
        else $error("zero flag wrong");
    add_sign_a: assert property (add_w |=> status_o[7] == $past(sum[15]))
        else $error("sign flag wrong");
    add_ovf_a: assert property (add_w |=> status_o[11] == $past(ovf))
        else $error("overflow flag wrong");
    trap_take_a: assert property (trap_armed_s |-> trap_fired_s)
        else $error("single step trap missing");
    ie_gate_a: assert property (!status_o[9] [*2] |-> !irq_take_o)
        else $error("request taken while disabled");
    ack_clear_a: assert property (irq_ack_i |=> !status_o[9])
        else $error("enable not cleared on take");
endmodule // cpu_status_regs_chk
bind cpu_status_regs cpu_status_regs_chk i_cpu_status_regs_chk (.clk_i, .reset_i, .exec_i,
    .irq_ack_i, .fetch_addr_o, .status_o, .irq_take_o, .trap_take_o, .vector_o);

// >>> sim/exec_unit_model.sv
// Execution unit model: issues instruction steps and takes accepted requests
`timescale 1ns/1ps
module exec_unit_model (
    input  wire logic               clk_i,      // Processor clock
    input  wire logic               reset_i,    // Asynchronous reset
    input  wire logic               irq_take_i, // Request accepted
    output cpu_regs_pkg::exec_req_t exec_o,     // Instruction step
    output logic                    irq_ack_o   // Request taken
);
    initial exec_o = '0;
    // One pulse per accepted request, so enable is cleared once
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) irq_ack_o <= 1'b0;
        else irq_ack_o <= irq_take_i && !irq_ack_o;
    end
    // Idle edge after each step keeps a second call off the same time step
    task automatic step(input cpu_regs_pkg::exec_req_t r);
        exec_o <= r;
        @(posedge clk_i);
        exec_o.valid <= 1'b0;
        @(posedge clk_i);
    endtask
endmodule // exec_unit_model

// >>> sim/tb_cpu_status_regs.sv
// Self-checking bench for the status flag and segment register datapath
`timescale 1ns/1ps
module tb_cpu_status_regs;
    logic                    clk_i, reset_i, hsel_i, hwrite_i, hready_i, hreadyout_o, hresp_o;
    logic                    irq_ack_i, maskable_irq_input_i, nmi_input_i, test_input_i;
    logic                    irq_take_o, trap_take_o, test_o, trap_seen, irq_seen;
    logic [31:0]             haddr_i, hwdata_i, hrdata_o, got;
    logic [19:0]             fetch_addr_o, phys_addr_o;
    logic [15:0]             status_o;
    logic [7:0]              vector_o;
    logic [2:0]              hsize_i;
    logic [1:0]              htrans_i;
    cpu_regs_pkg::exec_req_t exec_i;
    cpu_regs_pkg::addr_req_t addr_i;
    int                      fail_count, tests_run, cycles;
    localparam logic [15:0]  FA [4] = '{16'h7fff, 16'hffff, 16'h0000, 16'h0080};
    localparam logic [15:0]  FB [4] = '{16'h0001, 16'h0001, 16'h0001, 16'h0080};
    localparam logic [31:0]  FS [4] = '{32'h0894, 32'h0055, 32'h0095, 32'h0845};
    assign hready_i = hreadyout_o;
    always #10 clk_i = ~clk_i;
    cpu_status_regs i_cpu_status_regs (.clk_i, .reset_i, .hsel_i, .haddr_i, .htrans_i, .hwrite_i,
        .hsize_i, .hwdata_i, .hready_i, .hrdata_o, .hreadyout_o, .hresp_o, .exec_i, .addr_i,
        .irq_ack_i, .maskable_irq_input_i, .nmi_input_i, .test_input_i, .fetch_addr_o,
        .phys_addr_o, .status_o, .irq_take_o, .trap_take_o, .vector_o, .test_o);
    exec_unit_model i_exec_unit_model (.clk_i, .reset_i, .irq_take_i(irq_take_o),
        .exec_o(exec_i), .irq_ack_o(irq_ack_i));
    // ----------------
    // Tasks
    // ----------------
    task automatic test_done();
        $display("checks %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fail_count++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        hsel_i   <= 1'b1;
        haddr_i  <= {24'h000000, a};
        htrans_i <= 2'h2;
        hwrite_i <= wr;
        do @(posedge clk_i); while (hready_i !== 1'b1);
        hsel_i   <= 1'b0;
        htrans_i <= 2'h0;
        hwdata_i <= wd;
        do @(posedge clk_i); while (hready_i !== 1'b1);
        got = hrdata_o;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h00000000);
        check(got, exp);
    endtask
    task automatic ex(input cpu_regs_pkg::alu_op_t op, input logic bo, input logic [2:0] d,
                      input logic hi, input logic [15:0] a, input logic [15:0] b);
        i_exec_unit_model.step('{1'b1, op, bo, d, hi, a, b, 1'b0, 3'h0, 16'h0000});
    endtask
    task automatic str(input logic [2:0] sel);
        i_exec_unit_model.step('{1'b1, cpu_regs_pkg::OP_PASS, 1'b0, 3'h7, 1'b0, 16'h0000,
                                 16'h0000, 1'b1, sel, 16'h0000});
    endtask
    // A hang in a bus wait ends here
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (trap_take_o === 1'b1) trap_seen <= 1'b1;
        if (irq_take_o === 1'b1) irq_seen <= 1'b1;
        if (cycles == 3000) begin
            fail_count++;
            test_done();
        end
    end
    // ----------------
    // Stimulus
    // ----------------
    initial begin
        {clk_i, reset_i, hsel_i, hwrite_i, trap_seen, irq_seen} = 6'b010000;
        {maskable_irq_input_i, nmi_input_i, test_input_i} = 3'h0;
        {haddr_i, hwdata_i, htrans_i, addr_i} = '0;
        hsize_i = 3'h2;
        {cycles, fail_count, tests_run} = '0;
        repeat (12) @(posedge clk_i);
        reset_i <= 1'b0;
        @(posedge clk_i);
        for (int i = 0; i < 6; i++) rd(8'h20 + 8'(4 * i), (i == 1) ? 32'hffff : 32'h0);
        rd(8'h3c, 32'h000ffff0);
        for (int i = 0; i < 8; i++) bus(1'b1, 8'(4 * i), {16'hdead, 16'h1111 * 16'(i + 1)});
        for (int i = 0; i < 8; i++) rd(8'(4 * i), 32'h1111 * (i + 1));
        bus(1'b1, 8'h40, 32'h00001234);
        rd(8'h40, 32'h00000000);
        ex(cpu_regs_pkg::OP_PASS, 1'b1, 3'h0, 1'b1, 16'h00a5, 16'h00a5);
        ex(cpu_regs_pkg::OP_PASS, 1'b1, 3'h3, 1'b0, 16'h00a5, 16'h00a5);
        rd(8'h00, 32'h0000a511);
        rd(8'h0c, 32'h000044a5);
        for (int i = 0; i < 4; i++) begin
            ex((i == 2) ? cpu_regs_pkg::OP_SUB : cpu_regs_pkg::OP_ADD,
               i == 3, 3'h6, 1'b0, FA[i], FB[i]);
            rd(8'h20, FS[i]);
        end
        bus(1'b1, 8'h20, 32'hffffffff);
        rd(8'h20, 32'h00000fd5);
        ex(cpu_regs_pkg::OP_PASS, 1'b0, 3'h7, 1'b0, 16'h0000, 16'h0000);
        repeat (2) @(posedge clk_i);
        check({31'h0, trap_seen}, 32'h1);
        rd(8'h20, 32'h00000cd5);
        str(3'h0);
        bus(1'b1, 8'h20, 32'h00000200);
        maskable_irq_input_i <= 1'b1;
        test_input_i <= 1'b1;
        repeat (8) @(posedge clk_i);
        check({31'h0, irq_seen}, 32'h1);
        check({31'h0, test_o}, 32'h1);
        rd(8'h20, 32'h00000000);
        irq_seen <= 1'b0;
        rd(8'h38, 32'h00000005);
        check({31'h0, irq_seen}, 32'h0);
        str(3'h1);
        rd(8'h44, 32'h0001ffff);
        nmi_input_i <= 1'b1;
        repeat (4) @(posedge clk_i);
        check({24'h0, vector_o}, 32'h2);
        bus(1'b1, 8'h24, 32'h00001234);
        bus(1'b1, 8'h34, 32'h00000010);
        @(posedge clk_i);
        rd(8'h3c, 32'h00012350);
        bus(1'b1, 8'h28, 32'h0000abcd);
        addr_i <= '{2'h3, 16'hffff};
        repeat (2) @(posedge clk_i);
        check({12'h000, phys_addr_o}, 32'h000bbccf);
        reset_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        reset_i <= 1'b0;
        @(posedge clk_i);
        rd(8'h24, 32'h0000ffff);
        rd(8'h08, 32'h00003333);
        test_done();
    end
endmodule // tb_cpu_status_regs
